// [lane_rx_partner.sv]
// Purpose: Receiver model that requests sync and releases it on comma lock
// Assumes: Comma pair seen in either disparity form
// Notes:   hold_low lets the bench force a resync
`default_nettype none
module lane_rx_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [19:0] serial_lane_out_pair,
  input wire logic hold_low,
  output logic sync_request_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] comma_cnt_r;
  ////////////////////////////////////////
  // Lock needs four clean comma words in a row, any other word restarts the count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comma_cnt_r <= 3'h0;
      sync_request_in <= 1'b0;
    end else if (hold_low) begin
      comma_cnt_r <= 3'h0;
      sync_request_in <= 1'b0;
    end else if (!sync_request_in) begin
      if (serial_lane_out_pair inside {20'h3_eb05, 20'hc_14fa}) begin
        comma_cnt_r <= comma_cnt_r + 3'h1;
        sync_request_in <= comma_cnt_r == 3'h3;
      end else begin
        comma_cnt_r <= 3'h0;
      end
    end
  end
endmodule // lane_rx_partner
`default_nettype wire

// [lane_transmitter.v]
// Purpose: Single-lane transmit link layer: framing, scrambling, character
//          replacement, alignment sequence and 8b/10b encoding
// Assumes: One frame (two octets) per clk at 250 MHz, so 20 code bits per clk
//          feed a 5 Gbps serializer; sync_request_in is synchronous
// Notes:   Code bit a of each symbol sits in the MSB of its 10-bit half
`include "lane_tx_map.vh"
`default_nettype none

module lane_transmitter (
  input wire clk,
  input wire rst_n,
  input wire [13:0] sample_in,
  input wire overrange_in,
  input wire underrange_in,
  input wire sync_request_in,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg [19:0] serial_lane_out_pair,
  output reg frame_start
);
  localparam [2:0] ST_CGS = 3'b001;
  localparam [2:0] ST_ILAS = 3'b010;
  localparam [2:0] ST_DATA = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // 6-bit sub-block, negative disparity form
  function [5:0] tbl6;
    input [4:0] x;
    begin
      case (x)
        5'd0: tbl6 = 6'b100111;
        5'd1: tbl6 = 6'b011101;
        5'd2: tbl6 = 6'b101101;
        5'd3: tbl6 = 6'b110001;
        5'd4: tbl6 = 6'b110101;
        5'd5: tbl6 = 6'b101001;
        5'd6: tbl6 = 6'b011001;
        5'd7: tbl6 = 6'b111000;
        5'd8: tbl6 = 6'b111001;
        5'd9: tbl6 = 6'b100101;
        5'd10: tbl6 = 6'b010101;
        5'd11: tbl6 = 6'b110100;
        5'd12: tbl6 = 6'b001101;
        5'd13: tbl6 = 6'b101100;
        5'd14: tbl6 = 6'b011100;
        5'd15: tbl6 = 6'b010111;
        5'd16: tbl6 = 6'b011011;
        5'd17: tbl6 = 6'b100011;
        5'd18: tbl6 = 6'b010011;
        5'd19: tbl6 = 6'b110010;
        5'd20: tbl6 = 6'b001011;
        5'd21: tbl6 = 6'b101010;
        5'd22: tbl6 = 6'b011010;
        5'd23: tbl6 = 6'b111010;
        5'd24: tbl6 = 6'b110011;
        5'd25: tbl6 = 6'b100110;
        5'd26: tbl6 = 6'b010110;
        5'd27: tbl6 = 6'b110110;
        5'd28: tbl6 = 6'b001110;
        5'd29: tbl6 = 6'b101110;
        5'd30: tbl6 = 6'b011110;
        default: tbl6 = 6'b101011;
      endcase
    end
  endfunction

  // One octet to one symbol; returns {rd_out, abcdei, fghj}
  function [10:0] enc;
    input [7:0] d;
    input k;
    input rd;
    reg [5:0] c6;
    reg [3:0] c4;
    reg rd_mid;
    reg alt;
    reg un6;
    reg un4;
    begin
      c6 = k ? 6'b001111 : tbl6(d[4:0]);
      un6 = (c6[0] + c6[1] + c6[2] + c6[3] + c6[4] + c6[5]) != 3'd3;
      if (rd && (un6 || d[4:0] == 5'd7)) begin
        c6 = ~c6;
      end
      rd_mid = rd ^ un6;
      alt = k || (!rd_mid && (d[4:0] == 5'd17 || d[4:0] == 5'd18 || d[4:0] == 5'd20)) ||
            (rd_mid && (d[4:0] == 5'd11 || d[4:0] == 5'd13 || d[4:0] == 5'd14));
      case (d[7:5])
        3'd0: c4 = 4'b1011;
        3'd1: c4 = 4'b1001;
        3'd2: c4 = 4'b0101;
        3'd3: c4 = 4'b1100;
        3'd4: c4 = 4'b1101;
        3'd5: c4 = 4'b1010;
        3'd6: c4 = 4'b0110;
        default: c4 = alt ? 4'b0111 : 4'b1110;
      endcase
      un4 = (d[7:5] == 3'd0) || (d[7:5] == 3'd4) || (d[7:5] == 3'd7);
      // Control codes take the other balanced fghj form after a positive start
      if ((rd_mid && (un4 || d[7:5] == 3'd3)) || (k && !rd_mid && !un4 && d[7:5] != 3'd3)) begin
        c4 = ~c4;
      end
      enc = {rd_mid ^ un4, c6, c4};
    end
  endfunction

  // Sixteen bits through 1 + x^14 + x^15, first bit sent in the MSB
  function [30:0] scr16;
    input [15:0] d;
    input [14:0] s;
    reg [14:0] st;
    reg [15:0] o;
    integer i;
    begin
      st = s;
      o = 16'h0000;
      for (i = 15; i >= 0; i = i - 1) begin
        o[i] = d[i] ^ st[13] ^ st[14];
        st = {st[13:0], o[i]};
      end
      scr16 = {st, o};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  reg [7:0] ctrl_r;
  reg [4:0] kcfg_r;
  reg [7:0] devid_r;
  reg [3:0] bankid_r;
  reg [4:0] laneid_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  wire hold = ctrl_r[`CTRL_HOLD_BIT];
  wire scr_en = ctrl_r[`CTRL_SCR_BIT];
  wire prbs_en = ctrl_r[`CTRL_PRBS_BIT];
  wire [1:0] cs = ctrl_r[`CTRL_CS_HI:`CTRL_CS_LO];
  // Configuration octets as carried in the second alignment multiframe
  wire [7:0] cfg3 = {scr_en, 2'b00, `LANES_M1};
  wire [7:0] cfg5 = {3'b000, kcfg_r};
  wire [7:0] cfg7 = {cs, 1'b0, `RES_M1};
  wire [7:0] cfg8 = {`SUBCLASS_V, `BITS_M1};
  wire [7:0] cfg9 = {`VERSION_V, `SPF_M1};
  wire [7:0] cfg10 = {`HD_V, 2'b00, `CF_V};
  // Sum of every parameter field, mod 256; recomputed whenever a field changes
  wire [7:0] chksum = devid_r + {4'h0, bankid_r} + {3'b000, laneid_r} + {7'h00, scr_en} +
                      {3'b000, `LANES_M1} + `OCTETS_M1 + {3'b000, kcfg_r} + `CONV_M1 +
                      {6'h00, cs} + {3'b000, `RES_M1} + {5'h00, `SUBCLASS_V} +
                      {3'b000, `BITS_M1} + {5'h00, `VERSION_V} + {3'b000, `SPF_M1} +
                      {7'h00, `HD_V} + {3'b000, `CF_V};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `CTRL_RST;
      kcfg_r <= `KCFG_RST;
      devid_r <= `DEVID_RST;
      bankid_r <= `BANKID_RST;
      laneid_r <= `LANEID_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_CTRL: ctrl_r <= {3'b000, reg_wdata[4:0]};
        `REG_KCFG: kcfg_r <= reg_wdata[4:0];
        `REG_DEVID: devid_r <= reg_wdata;
        `REG_BANKID: bankid_r <= reg_wdata[3:0];
        `REG_LANEID: laneid_r <= reg_wdata[4:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Unmapped or idle reads return zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: reg_rdata <= ctrl_r;
        `REG_KCFG: reg_rdata <= {3'b000, kcfg_r};
        `REG_DEVID: reg_rdata <= devid_r;
        `REG_BANKID: reg_rdata <= {4'h0, bankid_r};
        `REG_LANEID: reg_rdata <= {3'b000, laneid_r};
        `REG_CHKSUM: reg_rdata <= chksum;
        `REG_STATUS: reg_rdata <= {5'h00, state_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase control and frame counting
  reg [4:0] fcnt_r;
  reg [1:0] mfcnt_r;
  wire mf_end = (fcnt_r == kcfg_r);
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_CGS: begin
        if (sync_request_in) begin
          state_nxt = ST_ILAS;
        end
      end
      ST_ILAS: begin
        if (!sync_request_in) begin
          state_nxt = ST_CGS;
        end else if (mf_end && mfcnt_r == `ILAS_MFS) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (!sync_request_in) begin
          state_nxt = ST_CGS;
        end
      end
      default: state_nxt = ST_CGS;
    endcase
    if (hold) begin
      state_nxt = ST_CGS;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_CGS;
      fcnt_r <= 5'h00;
      mfcnt_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r || state_r == ST_CGS) begin
        fcnt_r <= 5'h00;
        mfcnt_r <= 2'h0;
      end else begin
        fcnt_r <= mf_end ? 5'h00 : fcnt_r + 5'h01;
        if (mf_end) begin
          mfcnt_r <= mfcnt_r + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame assembly
  reg [14:0] prbs_r;
  reg [14:0] scr_r;
  reg [7:0] prev_last_r;
  reg rd_r;
  // Two extra bits: control bits take the top extra slots first
  reg [1:0] extra;
  always @* begin
    extra = prbs_en ? prbs_r[1:0] : 2'b00;
    case (cs)
      2'd1: extra = {overrange_in | underrange_in, extra[0]};
      2'd2, 2'd3: extra = {overrange_in, underrange_in};
      default: extra = extra;
    endcase
  end

  wire [15:0] frame = {sample_in[13:6], sample_in[5:0], extra};
  wire [30:0] scr_res = scr16(frame, scr_r);
  wire scr_on = scr_en && (state_r == ST_DATA);
  wire [15:0] data_oct = scr_on ? scr_res[15:0] : frame;
  // Octet index inside the multiframe, for alignment content
  wire [5:0] oct0_idx = {fcnt_r, 1'b0};
  wire [5:0] oct1_idx = {fcnt_r, 1'b1};
  function [7:0] cfg_oct;
    input [5:0] idx;
    begin
      case (idx)
        6'd2: cfg_oct = devid_r;
        6'd3: cfg_oct = {4'h0, bankid_r};
        6'd4: cfg_oct = {3'b000, laneid_r};
        6'd5: cfg_oct = cfg3;
        6'd6: cfg_oct = `OCTETS_M1;
        6'd7: cfg_oct = cfg5;
        6'd8: cfg_oct = `CONV_M1;
        6'd9: cfg_oct = cfg7;
        6'd10: cfg_oct = cfg8;
        6'd11: cfg_oct = cfg9;
        6'd12: cfg_oct = cfg10;
        6'd15: cfg_oct = chksum;
        default: cfg_oct = 8'h00;
      endcase
    end
  endfunction
  reg [7:0] o0;
  reg [7:0] o1;
  reg k0;
  reg k1;
  always @* begin
    o0 = data_oct[15:8];
    o1 = data_oct[7:0];
    k0 = 1'b0;
    k1 = 1'b0;
    case (state_r)
      ST_CGS: begin
        o0 = `K28_5;
        o1 = `K28_5;
        k0 = 1'b1;
        k1 = 1'b1;
      end
      ST_ILAS: begin
        if (mfcnt_r == 2'h1 && oct0_idx >= `CFG_FIRST && oct0_idx <= `CFG_LAST) begin
          o0 = cfg_oct(oct0_idx);
        end
        if (mfcnt_r == 2'h1 && oct1_idx >= `CFG_FIRST && oct1_idx <= `CFG_LAST) begin
          o1 = cfg_oct(oct1_idx);
        end
        if (fcnt_r == 5'h00) begin
          o0 = `K28_0;
          k0 = 1'b1;
          if (mfcnt_r == 2'h1) begin
            o1 = `K28_4;
            k1 = 1'b1;
          end
        end
        if (mf_end) begin
          o1 = `K28_3;
          k1 = 1'b1;
        end
      end
      ST_DATA: begin
        if (scr_en) begin
          if (mf_end && data_oct[7:0] == `SCR_A_MATCH) begin
            o1 = `K28_3;
            k1 = 1'b1;
          end else if (!mf_end && data_oct[7:0] == `SCR_F_MATCH) begin
            o1 = `K28_7;
            k1 = 1'b1;
          end
        end else if (data_oct[7:0] == prev_last_r) begin
          o1 = mf_end ? `K28_3 : `K28_7;
          k1 = 1'b1;
        end
      end
      default: o0 = data_oct[15:8];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Encoding and output
  wire [10:0] sym0 = enc(o0, k0, rd_r);
  wire [10:0] sym1 = enc(o1, k1, sym0[10]);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prbs_r <= `PRBS_SEED;
      scr_r <= 15'h0000;
      prev_last_r <= 8'h00;
      rd_r <= 1'b0;
      serial_lane_out_pair <= 20'h0_0000;
      frame_start <= 1'b0;
    end else begin
      prbs_r <= {prbs_r[12:0], prbs_r[14] ^ prbs_r[13], prbs_r[13] ^ prbs_r[12]};
      if (scr_on) begin
        scr_r <= scr_res[30:16];
      end
      // Compare against raw data, so a replaced octet never hides a repeat
      prev_last_r <= data_oct[7:0];
      rd_r <= sym1[10];
      serial_lane_out_pair <= {sym0[9:0], sym1[9:0]};
      frame_start <= (state_r != ST_CGS) && (fcnt_r == 5'h00);
    end
  end

endmodule // lane_transmitter

`default_nettype wire

// [lane_tx_asserts.sv]
// Purpose: Port-level checks for the lane transmitter
// Assumes: Hold bit stays clear; frames per multiframe change only while sync is low
// Notes:   Bound from the testbench top
`default_nettype none
module lane_tx_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sync_request_in,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [19:0] serial_lane_out_pair,
  input wire logic frame_start
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] k_r;
  logic [5:0] fcnt_r;
  logic seen_r;
  ////////////////////////////////////////
  // Shadow of frames per multiframe; spacing is only judged once a frame start was seen in this link
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      k_r <= 5'h1f;
      fcnt_r <= 6'h00;
      seen_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h01) begin
        k_r <= reg_wdata[4:0];
      end
      fcnt_r <= frame_start ? 6'h01 : fcnt_r + 6'h01;
      seen_r <= sync_request_in && (seen_r || frame_start);
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_cgs_comma: assert property (
    !sync_request_in ##1 !sync_request_in |=> serial_lane_out_pair inside {20'h3_eb05, 20'hc_14fa})
    else $error("comma pair missing during sync");
  chk_cgs_quiet: assert property (
    !sync_request_in ##1 !sync_request_in |=> !frame_start) else $error("frame start during sync");
  chk_ilas_start: assert property (
    !sync_request_in [*2] ##1 sync_request_in |-> ##2 frame_start && serial_lane_out_pair[19:10] == 10'h0f4)
    else $error("alignment start missing");
  chk_mf_period: assert property (
    seen_r |-> frame_start == (fcnt_r == {1'b0, k_r} + 6'h01)) else $error("multiframe length wrong");
  chk_rd_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data outside read slot");
  chk_rd_unmapped: assert property (
    reg_rd && reg_addr > 8'h06 |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_status_cgs: assert property (
    reg_rd && reg_addr == 8'h06 && !sync_request_in && $past(!sync_request_in) |=> reg_rdata == 8'h01)
    else $error("status not sync");
  chk_kcfg_echo: assert property (
    reg_rd && reg_addr == 8'h01 |=> reg_rdata == {3'h0, k_r}) else $error("frame count readback wrong");
  cov_release: cover property ($rose(sync_request_in));
  cov_mf: cover property (frame_start && seen_r);
  cov_csum: cover property (reg_rd && reg_addr == 8'h05);
endmodule // lane_tx_asserts
`default_nettype wire

// [lane_tx_map.vh]
// Purpose: Constants for the single-lane transmit link layer
// Assumes: Included by lane_transmitter.v only
// Notes:   Offsets are register indices on the plain register port
`ifndef LANE_TX_MAP_VH
`define LANE_TX_MAP_VH

// Register offsets
`define REG_CTRL 8'h00
`define REG_KCFG 8'h01
`define REG_DEVID 8'h02
`define REG_BANKID 8'h03
`define REG_LANEID 8'h04
`define REG_CHKSUM 8'h05
`define REG_STATUS 8'h06

// Control field positions
`define CTRL_HOLD_BIT 0
`define CTRL_SCR_BIT 1
`define CTRL_PRBS_BIT 2
`define CTRL_CS_LO 3
`define CTRL_CS_HI 4

// Reset values
`define CTRL_RST 8'h02
`define KCFG_RST 5'h1f
`define DEVID_RST 8'h00
`define BANKID_RST 4'h0
`define LANEID_RST 5'h00
`define PRBS_SEED 15'h7fff

// Fixed link parameters, minus one where the link carries them so
`define LANES_M1 5'h00
`define OCTETS_M1 8'h01
`define CONV_M1 8'h00
`define RES_M1 5'h0d
`define BITS_M1 5'h0f
`define SPF_M1 5'h00
`define SUBCLASS_V 3'h0
`define VERSION_V 3'h1
`define HD_V 1'b0
`define CF_V 5'h00

// Octet values and control character data
`define SCR_A_MATCH 8'h7c
`define SCR_F_MATCH 8'hfc
`define K28_0 8'h1c
`define K28_3 8'h7c
`define K28_4 8'h9c
`define K28_5 8'hbc
`define K28_7 8'hfc
`define ILAS_MFS 2'h3
`define CFG_FIRST 6'h02
`define CFG_LAST 6'h0f

`endif

// [tb_serial_converter_lane_transmitter.sv]
// Purpose: Self-checking bench for the lane transmitter
// Assumes: Receiver model releases sync after four comma words
// Notes:   Code words accepted in either disparity form
`default_nettype none
module tb_serial_converter_lane_transmitter;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, overrange_in, underrange_in, sync_request_in, reg_wr, reg_rd, frame_start, hold_low;
  logic [13:0] sample_in;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [19:0] serial_lane_out_pair;
  logic [7:0] rst_vals [8] = '{8'h02, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h3e, 8'h01, 8'h00};
  int error_cnt = 0;
  int num_checks = 0;
  lane_transmitter i_dut (.clk(clk), .rst_n(rst_n), .sample_in(sample_in), .overrange_in(overrange_in),
    .underrange_in(underrange_in), .sync_request_in(sync_request_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_lane_out_pair(serial_lane_out_pair), .frame_start(frame_start));
  lane_rx_partner i_rx (.clk(clk), .rst_n(rst_n), .serial_lane_out_pair(serial_lane_out_pair),
    .hold_low(hold_low), .sync_request_in(sync_request_in));
  ////////////////////////////////////////
  task automatic complete_run;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [9:0] s, input logic [9:0] a, input logic [9:0] b);
    num_checks++;
    if (s !== a && s !== b) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, a, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk("reg_rdata", {2'h0, reg_rdata}, {2'h0, e}, {2'h0, e});
  endtask
  // Link restarts around every config change so multiframe length never moves mid-stream
  task automatic relink(input logic [7:0] c, input logic [4:0] km);
    int i;
    int k;
    k = km + 1;
    hold_low <= 1'b1;
    wr(8'h00, c);
    wr(8'h01, {3'h0, km});
    @(posedge clk);
    hold_low <= 1'b0;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (frame_start !== 1'b1 && i < 3000);
    if (i >= 3000) begin
      error_cnt++;
      complete_run;
    end
    for (i = 0; i < 4 * k; i++) begin
      if (i % k == 0) chk("ilas_r", serial_lane_out_pair[19:10], 10'h0f4, 10'h30b);
      if (i % k == k - 1) chk("ilas_a", serial_lane_out_pair[9:0], 10'h0f3, 10'h30c);
      if (i == k) chk("ilas_q", serial_lane_out_pair[9:0], 10'h0f2, 10'h30d);
      if (i == k + 1) chk("ilas_did", serial_lane_out_pair[19:10], 10'h13b, 10'h134);
      @(posedge clk);
    end
    chk("data_start", {9'h000, frame_start}, 10'h001, 10'h001);
  endtask
  // Output word trails its inputs by two edges of this loop
  task automatic alt_run(input logic m, input logic [9:0] a0, b0, a1, b1);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (i >= 3) begin
        chk("octet0", serial_lane_out_pair[19:10], 10'h274, 10'h18b);
        chk("octet1", serial_lane_out_pair[9:0], i[0] ? a1 : a0, i[0] ? b1 : b0);
      end
      sample_in <= {13'h0000, !m && i[0]};
      overrange_in <= m && i[0];
      underrange_in <= m && !i[0];
    end
  endtask
  task automatic const_run;
    int i;
    logic [9:0] p;
    p = 10'h000;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (i >= 4) chk("repl", p, frame_start ? 10'h0f3 : 10'h0f8, frame_start ? 10'h30c : 10'h307);
      p = serial_lane_out_pair[9:0];
      sample_in <= 14'h0000;
      overrange_in <= i[0];
      underrange_in <= !i[0];
    end
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    sample_in = 14'h0000;
    overrange_in = 1'b0;
    underrange_in = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    hold_low = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int j = 0; j < 8; j++) rd(j[7:0], rst_vals[j]);
    wr(8'h02, 8'h12);
    wr(8'h03, 8'hff);
    wr(8'h04, 8'hff);
    wr(8'h05, 8'h55);
    wr(8'h07, 8'haa);
    rd(8'h03, 8'h0f);
    rd(8'h04, 8'h1f);
    rd(8'h05, 8'h7e);
    // Twelve frames keep the checksum octet clear of the closing K28.3
    relink(8'h00, 5'h0b);
    alt_run(1'b0, 10'h274, 10'h18b, 10'h354, 10'h0ab);
    const_run;
    relink(8'h10, 5'h0b);
    rd(8'h05, 8'h6b);
    alt_run(1'b1, 10'h1d4, 10'h22b, 10'h2d4, 10'h12b);
    relink(8'h08, 5'h1f);
    const_run;
    sample_in <= 14'h003f;
    relink(8'h02, 5'h0b);
    chk("scr_f", serial_lane_out_pair[9:0], 10'h0f8, 10'h307);
    chk("scr_o0", serial_lane_out_pair[19:10], 10'h274, 10'h18b);
    rd(8'h06, 8'h04);
    complete_run;
  end
endmodule // tb_serial_converter_lane_transmitter
bind lane_transmitter lane_tx_asserts i_chk (.clk(clk), .rst_n(rst_n), .sync_request_in(sync_request_in),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .serial_lane_out_pair(serial_lane_out_pair), .frame_start(frame_start));
`default_nettype wire
